// ### logic/arcs_pkg.sv
package arcs_pkg;
	// Register indices; each byte address is four times its index.
	localparam logic [7:0] MODE_IDX        = 8'h01;
	localparam logic [7:0] SETUP0_IDX      = 8'h20;
	localparam logic [9:0] MODE_ADDR       = {MODE_IDX, 2'b00};
	localparam logic [9:0] SETUP0_ADDR     = {SETUP0_IDX, 2'b00};
	localparam logic [9:0] STATUS_ADDR     = 10'h204;
	localparam logic [15:0] MODE_RST       = 16'h2000;
	localparam logic [15:0] SETUP0_RST     = 16'h1000;
	// Writable bit masks; reserved bits read as zero.
	localparam logic [15:0] MODE_WMASK     = 16'ha77c;
	localparam logic [15:0] SETUP0_WMASK   = 16'h1f30;
	// Mode register fields.
	localparam int REF_EN_BIT              = 15;
	localparam int SINGLE_CYCLE_SETTLING_BIT            = 13;
	localparam int CLKSEL_LO               = 2;
	// Setup register fields.
	localparam int POLARITY_BIT            = 12;
	localparam int POS_BUF_BIT             = 11;
	localparam int NEG_BUF_BIT             = 10;
	localparam int INBUF_LO                = 8;
	localparam int REFSEL_LO               = 4;
	// Divide-by-four from 16 MHz to 4 MHz: toggle every two source edges.
	localparam logic [1:0] DIV_HALF        = 2'd1;
	localparam logic [1:0] AXI_OKAY        = 2'b00;
	localparam logic [1:0] AXI_SLVERR      = 2'b10;
	typedef enum logic [1:0] {
		ARCS_CLK_INT     = 2'b00,
		ARCS_CLK_INT_OUT = 2'b01,
		ARCS_CLK_EXT     = 2'b10,
		ARCS_CLK_XTAL    = 2'b11
	} arcs_clksel_e;
	typedef enum logic [1:0] {
		ARCS_REF_EXT  = 2'b00,
		ARCS_REF_AVDD = 2'b10,
		ARCS_REF_INT  = 2'b01,
		ARCS_REF_RSV  = 2'b11
	} arcs_refsel_e;
endpackage

// ### logic/arcs_clock_select.sv
`timescale 1ns/1ps
module arcs_clock_select import arcs_pkg::*; (
	// System.
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite slave.
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Clock sources, sampled on clk.
	input  wire logic        osc_clk,
	input  wire logic        crystal_input_pin,
	input  wire logic        clock_io_pin_in,
	output logic             clock_io_pin_out,
	output logic             clock_io_pin_oe_n,
	// Master clock and analog controls.
	output logic             master_clk,
	output logic             reference_enable,
	output logic             reference_output_pin_drive,
	output logic [1:0]       reference_source_select,
	output logic             output_polarity_select,
	output logic             positive_reference_buffer_enable,
	output logic             negative_reference_buffer_enable,
	output logic [1:0]       input_buffer_enable,
	output logic             single_cycle_settling
);

	logic [15:0] mode_r;
	logic [15:0] setup_r;
	logic        aw_got_r;
	logic        w_got_r;
	logic [9:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [2:0]  osc_sync_r;
	logic [2:0]  xtal_sync_r;
	logic [1:0]  ext_sync_r;
	logic [1:0]  osc_cnt_r;
	logic [1:0]  xtal_cnt_r;
	logic        osc_div_r;
	logic        xtal_div_r;
	logic        master_clk_r;
	logic        pin_out_r;
	logic        pin_oe_n_r;
	arcs_clksel_e clksel;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		return (v & m) | (old & ~m);
	endfunction

	function automatic logic addr_ok(input logic [9:0] a);
		return (a == MODE_ADDR) || (a == SETUP0_ADDR) || (a == STATUS_ADDR);
	endfunction

	// Write channel: address and data taken in either order, answer after both.
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_r && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 10'h000;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (aw_got_r && w_got_r) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
		end else if (aw_got_r && w_got_r) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_ok(awaddr_r) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register file; reset returns both registers to defaults.
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r  <= MODE_RST;
			setup_r <= SETUP0_RST;
		end else if (aw_got_r && w_got_r) begin
			if (awaddr_r == MODE_ADDR) begin
				mode_r <= merge16(mode_r, wdata_r, wstrb_r, MODE_WMASK);
			end
			if (awaddr_r == SETUP0_ADDR) begin
				setup_r <= merge16(setup_r, wdata_r, wstrb_r, SETUP0_WMASK);
			end
		end
	end

	// Read channel.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_ok(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
			case (s_axi_araddr)
				MODE_ADDR:   s_axi_rdata <= {16'h0000, mode_r};
				SETUP0_ADDR: s_axi_rdata <= {16'h0000, setup_r};
				STATUS_ADDR: s_axi_rdata <= {29'h0, pin_oe_n_r, master_clk_r, reference_enable};
				default:     s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Pin synchronisers; only the second stage onward feeds logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_sync_r  <= 3'b000;
			xtal_sync_r <= 3'b000;
			ext_sync_r  <= 2'b00;
		end else begin
			osc_sync_r  <= {osc_sync_r[1:0], osc_clk};
			xtal_sync_r <= {xtal_sync_r[1:0], crystal_input_pin};
			ext_sync_r  <= {ext_sync_r[0], clock_io_pin_in};
		end
	end

	// Divide the 16 MHz sources by four via rising-edge counting.
	// A source faster than half of clk would lose edges and divide wrongly.
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_cnt_r  <= 2'd0;
			osc_div_r  <= 1'b0;
		end else if (osc_sync_r[1] && !osc_sync_r[2]) begin
			osc_cnt_r <= (osc_cnt_r == DIV_HALF) ? 2'd0 : osc_cnt_r + 2'd1;
			if (osc_cnt_r == DIV_HALF) begin
				osc_div_r <= !osc_div_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			xtal_cnt_r <= 2'd0;
			xtal_div_r <= 1'b0;
		end else if (xtal_sync_r[1] && !xtal_sync_r[2]) begin
			xtal_cnt_r <= (xtal_cnt_r == DIV_HALF) ? 2'd0 : xtal_cnt_r + 2'd1;
			if (xtal_cnt_r == DIV_HALF) begin
				xtal_div_r <= !xtal_div_r;
			end
		end
	end

	assign clksel = arcs_clksel_e'(mode_r[CLKSEL_LO +: 2]);

	// Master clock mux; every data rate downstream derives from it.
	always_ff @(posedge clk) begin
		if (rst) begin
			master_clk_r <= 1'b0;
			pin_out_r    <= 1'b0;
			pin_oe_n_r   <= 1'b1;
		end else begin
			case (clksel)
				ARCS_CLK_INT: begin
					master_clk_r <= osc_div_r;
					pin_oe_n_r   <= 1'b1;
				end
				// The pin mirrors the synchronised oscillator, one cycle late.
				ARCS_CLK_INT_OUT: begin
					master_clk_r <= osc_div_r;
					pin_out_r    <= osc_sync_r[1];
					pin_oe_n_r   <= 1'b0;
				end
				ARCS_CLK_EXT: begin
					master_clk_r <= ext_sync_r[1];
					pin_oe_n_r   <= 1'b1;
				end
				ARCS_CLK_XTAL: begin
					master_clk_r <= xtal_div_r;
					pin_oe_n_r   <= 1'b1;
				end
				default: begin
					master_clk_r <= osc_div_r;
					pin_oe_n_r   <= 1'b1;
				end
			endcase
		end
	end

	assign master_clk        = master_clk_r;
	assign clock_io_pin_out  = pin_out_r;
	assign clock_io_pin_oe_n = pin_oe_n_r;

	assign reference_enable                 = mode_r[REF_EN_BIT];
	assign reference_output_pin_drive       = mode_r[REF_EN_BIT];
	assign single_cycle_settling            = mode_r[SINGLE_CYCLE_SETTLING_BIT];
	assign reference_source_select          = setup_r[REFSEL_LO +: 2];
	assign output_polarity_select           = setup_r[POLARITY_BIT];
	assign positive_reference_buffer_enable = setup_r[POS_BUF_BIT];
	assign negative_reference_buffer_enable = setup_r[NEG_BUF_BIT];
	assign input_buffer_enable              = setup_r[INBUF_LO +: 2];

	// A write completes once both channels are latched; its answer follows one edge later.
	sequence seq_write_pair;
		aw_got_r && w_got_r;
	endsequence

	sequence seq_mode_write;
		aw_got_r && w_got_r && (awaddr_r == MODE_ADDR) && wstrb_r[1];
	endsequence

	sequence seq_setup_write;
		aw_got_r && w_got_r && (awaddr_r == SETUP0_ADDR) && wstrb_r[1];
	endsequence

	sequence seq_read_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	chk_ref_follows_bit: assert property (@(posedge clk) disable iff (rst)
		seq_mode_write |=> reference_output_pin_drive == $past(wdata_r[REF_EN_BIT]))
		else $error("reference pin drive differs from written enable bit");

	chk_write_answer: assert property (@(posedge clk) disable iff (rst)
		seq_write_pair |=> s_axi_bvalid && !aw_got_r && !w_got_r)
		else $error("write answer missing after both channels taken");

	chk_bvalid_clear: assert property (@(posedge clk) disable iff (rst)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not withdrawn after acceptance");

	chk_read_answer: assert property (@(posedge clk) disable iff (rst)
		seq_read_take |=> s_axi_rvalid)
		else $error("read answer missing after address taken");

	chk_rvalid_clear: assert property (@(posedge clk) disable iff (rst)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not withdrawn after acceptance");

	chk_regs_hold: assert property (@(posedge clk) disable iff (rst)
		!(aw_got_r && w_got_r) |=> $stable(mode_r) && $stable(setup_r))
		else $error("register changed without a write");

	chk_reset_ref_off: assert property (@(posedge clk)
		$past(rst) |-> !reference_enable)
		else $error("reference on after reset");

	chk_reset_int_osc: assert property (@(posedge clk)
		$past(rst) |-> mode_r[CLKSEL_LO +: 2] == ARCS_CLK_INT)
		else $error("clock source not internal after reset");

	chk_ext_passthru: assert property (@(posedge clk) disable iff (rst)
		(clksel == ARCS_CLK_EXT) && $stable(clksel) |=> master_clk_r == $past(ext_sync_r[1]))
		else $error("external clock not passed through");

	chk_pin_drive_mode: assert property (@(posedge clk) disable iff (rst)
		(clksel == ARCS_CLK_INT_OUT) |=> !pin_oe_n_r)
		else $error("clock pin not driven in output mode");

	chk_pin_float_mode: assert property (@(posedge clk) disable iff (rst)
		(clksel != ARCS_CLK_INT_OUT) |=> pin_oe_n_r)
		else $error("clock pin driven outside output mode");

	chk_mode_reset_val: assert property (@(posedge clk)
		$past(rst) |-> mode_r == MODE_RST && setup_r == SETUP0_RST)
		else $error("register reset value wrong");

	chk_osc_div_hold: assert property (@(posedge clk) disable iff (rst)
		!(osc_sync_r[1] && !osc_sync_r[2]) |=> $stable(osc_div_r))
		else $error("divider toggled without oscillator edge");

	chk_setup_polarity: assert property (@(posedge clk) disable iff (rst)
		seq_setup_write |=> output_polarity_select == $past(wdata_r[POLARITY_BIT]))
		else $error("polarity output differs from written bit");

	chk_xtal_div_hold: assert property (@(posedge clk) disable iff (rst)
		!(xtal_sync_r[1] && !xtal_sync_r[2]) |=> $stable(xtal_div_r))
		else $error("divider toggled without crystal edge");

	chk_master_int: assert property (@(posedge clk) disable iff (rst)
		(clksel == ARCS_CLK_INT) |=> master_clk_r == $past(osc_div_r))
		else $error("master clock not from divided oscillator");

	chk_master_xtal: assert property (@(posedge clk) disable iff (rst)
		(clksel == ARCS_CLK_XTAL) |=> master_clk_r == $past(xtal_div_r))
		else $error("master clock not from divided crystal");

	chk_pin_follows_osc: assert property (@(posedge clk) disable iff (rst)
		(clksel == ARCS_CLK_INT_OUT) |=> clock_io_pin_out == $past(osc_sync_r[1]))
		else $error("clock pin does not follow oscillator");

endmodule // arcs_clock_select

// ### bench/arcs_clk_src.sv
`timescale 1ns/1ps
module arcs_clk_src (
	// Clock sources.
	output logic osc_clk,
	output logic crystal_clk,
	output logic ext_clk
);
	// The crystal stays still until its oscillation has built up.
	initial begin
		crystal_clk = 1'b0;
		#2000;
		forever #31.25 crystal_clk = ~crystal_clk;
	end
	// The internal oscillator runs at 16 MHz.
	initial begin
		osc_clk = 1'b0;
		forever #31.25 osc_clk = ~osc_clk;
	end
	// The external source runs below the nominal rate, at 2 MHz.
	initial begin
		ext_clk = 1'b0;
		forever #250 ext_clk = ~ext_clk;
	end
endmodule // arcs_clk_src

// ### bench/tb_adc_reference_clock_select.sv
`timescale 1ns/1ps
module tb_adc_reference_clock_select import arcs_pkg::*;;
	logic        clk = 1'b0;
	logic        rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
	logic        osc, xtl, ext, pin_in, pin_out, pin_oe_n, mclk;
	logic        ref_en, ref_pin, pol, pbuf, nbuf, scs;
	logic [9:0]  awa, ara;
	logic [31:0] wd, rdat, v, seed, q;
	logic [15:0] mv, sv;
	logic [3:0]  ws, stb;
	logic [1:0]  br, rr, rsel, ibuf, r;
	int          fail_count, compares, m, p;

	// The pin carries the device's drive while enabled, else the outside clock.
	assign pin_in = pin_oe_n ? ext : pin_out;
	always #2 clk = ~clk;

	arcs_clk_src src (.osc_clk(osc), .crystal_clk(xtl), .ext_clk(ext));

	arcs_clock_select dut (
		.clk(clk), .rst(rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.osc_clk(osc), .crystal_input_pin(xtl), .clock_io_pin_in(pin_in),
		.clock_io_pin_out(pin_out), .clock_io_pin_oe_n(pin_oe_n), .master_clk(mclk),
		.reference_enable(ref_en), .reference_output_pin_drive(ref_pin),
		.reference_source_select(rsel), .output_polarity_select(pol),
		.positive_reference_buffer_enable(pbuf),
		.negative_reference_buffer_enable(nbuf),
		.input_buffer_enable(ibuf), .single_cycle_settling(scs)
	);

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// Master clock rising edges expected in n cycles of 4 ns.
	function automatic int edges(input logic [1:0] s, input int n);
		return (s == ARCS_CLK_EXT) ? n * 4 / 500 : n * 4 / 250;
	endfunction

	function automatic logic near(input int a, input int b);
		return (a >= b - 2) && (a <= b + 2);
	endfunction

	// Expected register after a write: strobed byte lanes take new data, writable bits only.
	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] m);
		logic [15:0] k;
		k = {{8{s[1]}}, {8{s[0]}}} & m;
		return (old & ~k) | (d[15:0] & k);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (fail_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [9:0] a, input logic [31:0] d, output logic [1:0] res);
		int i;
		@(posedge clk);
		awa <= a;
		wd <= d;
		ws <= stb;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) break;
		end
		res = br;
		bre <= 1'b0;
		if (i == 50) begin
			fail_count++;
			tally_and_finish;
		end
	endtask

	task automatic rd_reg(input logic [9:0] a, output logic [31:0] d, output logic [1:0] res);
		int i;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		d = rdat;
		res = rr;
		rre <= 1'b0;
		if (i == 50) begin
			fail_count++;
			tally_and_finish;
		end
	endtask

	task automatic cnt(input int n, output int mc, output int pc);
		logic pm, pp;
		int i;
		mc = 0;
		pc = 0;
		pm = mclk;
		pp = pin_out;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			if (mclk && !pm) mc++;
			if (pin_out && !pp) pc++;
			pm = mclk;
			pp = pin_out;
		end
	endtask

	initial begin
		rst = 1'b1;
		stb = 4'h3;
		mv = MODE_RST;
		sv = SETUP0_RST;
		{awv, wv, bre, arv, rre, awa, ara, wd, ws} = '0;
		fail_count = 0;
		compares = 0;
		seed = 32'h8f2e197d;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_reg(MODE_ADDR, v, r);
		chk(v, 32'h2000);
		rd_reg(SETUP0_ADDR, v, r);
		chk(v, 32'h1000);
		chk(ref_en, 1'b0);
		chk(rsel, ARCS_REF_EXT);
		rd_reg(10'h3fc, v, r);
		chk(r, AXI_SLVERR);
		chk(v, 32'h0);
		rd_reg(STATUS_ADDR, q, r);
		chk(q & 32'h5, 32'h4);
		wr_reg(10'h3fc, 32'hffff, r);
		chk(r, AXI_SLVERR);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : seed;
			stb = (i < 2) ? 4'h3 : seed[27:24];
			wr_reg(MODE_ADDR, v, r);
			chk(r, AXI_OKAY);
			mv = lanes(mv, v, stb, MODE_WMASK);
			rd_reg(MODE_ADDR, q, r);
			chk(r, AXI_OKAY);
			chk(q, {16'h0, mv});
			chk({ref_en, ref_pin, scs}, {mv[15], mv[15], mv[13]});
			wr_reg(SETUP0_ADDR, v, r);
			chk(r, AXI_OKAY);
			sv = lanes(sv, v, stb, SETUP0_WMASK);
			rd_reg(SETUP0_ADDR, q, r);
			chk(q, {16'h0, sv});
			chk(pol, sv[12]);
			chk({pbuf, nbuf, ibuf, rsel}, {sv[11:8], sv[5:4]});
		end
		stb = 4'h3;
		for (int s = 0; s < 4; s++) begin
			wr_reg(MODE_ADDR, {28'h0, s[1:0], 2'b00}, r);
			repeat (20) @(posedge clk);
			cnt(2500, m, p);
			chk(near(m, edges(s[1:0], 2500)), 1'b1);
			chk(pin_oe_n, s != 1);
			if (s == 1) chk(near(p, 160), 1'b1);
		end
		wr_reg(MODE_ADDR, 32'h8008, r);
		chk(ref_en, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(MODE_ADDR, v, r);
		chk(v, 32'h2000);
		chk({ref_en, pin_oe_n}, 2'b01);
		cnt(2500, m, p);
		chk(near(m, 40), 1'b1);
		wr_reg(MODE_ADDR, 32'h8000, r);
		chk(ref_en, 1'b1);
		// Software keeps the on-chip reference off while an external one is used.
		wr_reg(MODE_ADDR, 32'h2000, r);
		chk(ref_en, 1'b0);
		tally_and_finish;
	end
endmodule // tb_adc_reference_clock_select
